// ===== rtl/afma_pkg.sv
// shared constants, encodings and carriers for the execution datapath
package afma_pkg;

   // instruction bit positions
   localparam int B_S = 20;
   localparam int B_L = 20;
   localparam int B_A = 21;
   localparam int B_W = 21;
   localparam int B_SGN = 22;
   localparam int B_R = 22;
   localparam int B_B = 22;
   localparam int B_HIMM = 22;
   localparam int B_U = 23;
   localparam int B_P = 24;
   localparam int B_I = 25;
   localparam int B_HS = 6;
   localparam int B_HH = 5;
   localparam int OPC_HI = 24;
   localparam int OPC_LO = 21;
   localparam int SHA_HI = 11;
   localparam int SHA_LO = 7;
   localparam int SHT_HI = 6;
   localparam int SHT_LO = 5;
   localparam int MSK_LO = 16;
   localparam int IMM12_HI = 11;
   localparam int HOFF_HI = 11;
   localparam int HOFF_LO = 8;
   localparam int LOFF_HI = 3;

   // status register layout
   localparam int SR_N = 31;
   localparam int SR_Z = 30;
   localparam int SR_C = 29;
   localparam int SR_V = 28;
   localparam int FLD_BITS = 8;
   localparam logic [31:0] SR_WMASK = 32'hf00000ff;
   localparam logic [31:0] SR_RESET = 32'h000000c0;

   // data-processing opcodes
   typedef enum logic [3:0] {
      OP_AND = 4'b0000, OP_EOR = 4'b0001, OP_SUB = 4'b0010,
      OP_RSB = 4'b0011, OP_ADD = 4'b0100, OP_ADC = 4'b0101,
      OP_SBC = 4'b0110, OP_RSC = 4'b0111, OP_TST = 4'b1000,
      OP_TEQ = 4'b1001, OP_CMP = 4'b1010, OP_CMN = 4'b1011,
      OP_ORR = 4'b1100, OP_MOV = 4'b1101, OP_BIC = 4'b1110,
      OP_MVN = 4'b1111
   } afma_op_e;

   // instruction classes handled here
   typedef enum logic [2:0] {
      CL_DP = 3'b000, CL_MUL = 3'b001, CL_MULL = 3'b010,
      CL_MRS = 3'b011, CL_MSR = 3'b100, CL_LSW = 3'b101,
      CL_LSH = 3'b110, CL_NONE = 3'b111
   } afma_cls_e;

   typedef enum logic [1:0] {
      SH_LSL = 2'b00, SH_LSR = 2'b01, SH_ASR = 2'b10, SH_ROR = 2'b11
   } afma_sh_e;

   typedef enum logic [1:0] {
      SZ_BYTE = 2'b00, SZ_HALF = 2'b01, SZ_WORD = 2'b10
   } afma_size_e;

   typedef enum logic [2:0] {
      LK_WORD = 3'b000, LK_UBYTE = 3'b001, LK_UHALF = 3'b010,
      LK_SHALF = 3'b011, LK_SBYTE = 3'b100
   } afma_lk_e;

   typedef struct packed {
      logic n;
      logic z;
      logic c;
      logic v;
   } afma_flags_s;

   typedef struct packed {
      logic write;
      afma_size_e size;
      logic [31:0] addr;
      logic [31:0] wdata;
   } afma_memreq_s;

endpackage

// ===== rtl/afma_mul.sv
// 32x32 multiplier with 64-bit accumulate, signed or unsigned
`timescale 1ns/1ps
module afma_mul (
   // operands
   input wire logic [31:0] a,
   input wire logic [31:0] b,
   input wire logic [63:0] acc,
   input wire logic sgn,
   // product plus accumulator
   output logic [63:0] res
);
   logic signed [32:0] ax;
   logic signed [32:0] bx;
   logic signed [65:0] prod;

   // one extra bit lets one multiplier serve both signednesses
   always_comb begin
      ax = $signed({sgn & a[31], a});
      bx = $signed({sgn & b[31], b});
      prod = ax * bx;
      res = prod[63:0] + acc;
   end
endmodule // afma_mul

// ===== rtl/afma_core.sv
// execution datapath: flags, multiplies, status moves, address generation
//
// Behaviour
// RULE1 - N flag copies result bit 31
// RULE2 - Z flag set exactly when result zero
// RULE3 - add/sub/compare carry from 32-bit adder
// RULE4 - logical/move carry comes from shifter
// RULE5 - arithmetic sets V; logical leaves V
// RULE6 - plain multiply keeps low 32 product bits
// RULE7 - accumulate adds third register, truncated
// RULE8 - short multiplies sign-agnostic, touch only N,Z
// RULE9 - long multiply writes 64-bit product, signedness
// RULE10 - long accumulate adds 64-bit pair; N,Z optional
// RULE11 - both status registers readable and writable
// RULE12 - status writes masked per byte field
// RULE13 - flags field top; status, extension unused
// RULE14 - control field: interrupts, mode, state bit
// RULE15 - word, byte, halfword, signed loads supported
// RULE16 - 12-bit immediate offset added or subtracted
// RULE17 - register offset added or subtracted
// RULE18 - scaled register offset with four shifts
// RULE19 - offset form leaves base unchanged
// RULE20 - pre-indexed accesses and writes new base
// RULE21 - post-indexed accesses base, writes new base
// RULE22 - halfword forms: 8-bit immediate, no scaling
// RULE23 - unsigned halfword load zero-fills top
// RULE24 - bit 20 gates flag update
// RULE25 - compares always update flags, no write
// RULE26 - signed loads replicate top data bit
`timescale 1ns/1ps
module afma_core (
   // clock and reset
   input wire logic CLK,
   input wire logic SRST,
   // issue group
   input wire logic ISSUE,
   input wire logic [31:0] INSTR,
   input wire logic [31:0] OP_A,
   input wire logic [31:0] OP_B,
   input wire logic [31:0] OP_C,
   input wire logic [31:0] OP_D,
   input wire logic SHIFT_CARRY,
   // result group
   output logic DONE,
   output logic [31:0] RESULT,
   output logic [31:0] RESULT_HI,
   output logic RD_WE,
   output logic RD_HI_WE,
   output logic [31:0] STATUS,
   output logic [31:0] SAVED_STATUS,
   // memory request and base writeback
   output logic MEM_REQ,
   output afma_pkg::afma_memreq_s MEM_OUT,
   output logic BASE_WE,
   output logic [31:0] BASE_VALUE,
   // load return
   input wire logic MEM_RVALID,
   input wire logic [31:0] MEM_RDATA,
   output logic LOAD_VALID,
   output logic [31:0] LOAD_DATA
);

   // byte-field merge used for both status registers
   function automatic logic [31:0] sr_merge(input logic [31:0] old,
      input logic [31:0] val, input logic [3:0] msk);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (msk[i]) begin
            r[i*afma_pkg::FLD_BITS +: afma_pkg::FLD_BITS] =
               val[i*afma_pkg::FLD_BITS +: afma_pkg::FLD_BITS];
         end
      end
      return r & afma_pkg::SR_WMASK;
   endfunction

   // immediate shift of a register offset
   function automatic logic [31:0] shift_imm(input logic [31:0] v,
      input logic [4:0] amt, input afma_pkg::afma_sh_e typ,
      input logic cin);
      logic [31:0] r;
      logic [5:0] back;
      r = v;
      back = 6'(6'd32 - {1'b0, amt});
      case (typ)
         afma_pkg::SH_LSL: r = v << amt;
         afma_pkg::SH_LSR: r = (amt == 5'h00) ? 32'h0 : v >> amt;
         afma_pkg::SH_ASR: begin
            r = (amt == 5'h00) ? {32{v[31]}} : 32'($signed(v) >>> amt);
         end
         afma_pkg::SH_ROR: begin
            // amount zero is rotate-through-carry by one
            r = (amt == 5'h00) ? {cin, v[31:1]} :
               ((v >> amt) | (v << back));
         end
         default: r = v;
      endcase
      return r;
   endfunction

   // sign or zero extension of returned load data
   function automatic logic [31:0] extend(input logic [31:0] d,
      input afma_pkg::afma_lk_e k);
      logic [31:0] r;
      r = d;
      case (k)
         afma_pkg::LK_UBYTE: r = {24'h0, d[7:0]};
         afma_pkg::LK_UHALF: r = {16'h0, d[15:0]};
         afma_pkg::LK_SHALF: r = {{16{d[15]}}, d[15:0]};
         afma_pkg::LK_SBYTE: r = {{24{d[7]}}, d[7:0]};
         default: r = d;
      endcase
      return r;
   endfunction

   afma_pkg::afma_cls_e cls;
   afma_pkg::afma_op_e opc;
   afma_pkg::afma_flags_s flg_q;
   afma_pkg::afma_lk_e lk_d;
   afma_pkg::afma_lk_e lk_q;
   logic [31:0] cps_q;
   logic [31:0] sps_q;
   logic s_bit;
   logic is_cmp;
   logic [31:0] alu_x;
   logic [31:0] alu_y;
   logic alu_ci;
   logic arith;
   logic [31:0] logic_r;
   logic [32:0] sum;
   logic [31:0] alu_r;
   logic alu_c;
   logic alu_v;
   logic [63:0] mul_acc;
   logic [63:0] mul_r;
   logic [31:0] offs;
   logic [31:0] calc;
   afma_pkg::afma_size_e size_d;
   logic [31:0] msr_val;

   assign opc = afma_pkg::afma_op_e'(INSTR[afma_pkg::OPC_HI:afma_pkg::OPC_LO]);
   assign s_bit = INSTR[afma_pkg::B_S];
   assign is_cmp = (opc[3:2] == 2'b10);
   assign flg_q = afma_pkg::afma_flags_s'(cps_q[31:28]);
   assign msr_val = OP_B;

   // class decode; multiply patterns take precedence over data-processing
   always_comb begin
      if (INSTR[27:22] == 6'b000000 && INSTR[7:4] == 4'b1001) begin
         cls = afma_pkg::CL_MUL;
      end else if (INSTR[27:23] == 5'b00001 && INSTR[7:4] == 4'b1001) begin
         cls = afma_pkg::CL_MULL;
      end else if (INSTR[27:25] == 3'b000 && INSTR[7] && INSTR[4] &&
                   INSTR[6:5] != 2'b00) begin
         cls = afma_pkg::CL_LSH;
      end else if (INSTR[27:23] == 5'b00010 && INSTR[21:20] == 2'b00) begin
         cls = afma_pkg::CL_MRS;
      end else if ((INSTR[27:23] == 5'b00010 || INSTR[27:23] == 5'b00110)
                   && INSTR[21:20] == 2'b10) begin
         cls = afma_pkg::CL_MSR;
      end else if (INSTR[27:26] == 2'b01) begin
         cls = afma_pkg::CL_LSW;
      end else if (INSTR[27:26] == 2'b00) begin
         cls = afma_pkg::CL_DP;
      end else begin
         cls = afma_pkg::CL_NONE;
      end
   end

   // alu: subtracts feed the inverted operand so carry means no borrow
   always_comb begin
      alu_x = OP_A;
      alu_y = OP_B;
      alu_ci = 1'b0;
      arith = 1'b1;
      logic_r = 32'h0;
      case (opc)
         afma_pkg::OP_AND, afma_pkg::OP_TST: begin
            arith = 1'b0;
            logic_r = OP_A & OP_B;
         end
         afma_pkg::OP_EOR, afma_pkg::OP_TEQ: begin
            arith = 1'b0;
            logic_r = OP_A ^ OP_B;
         end
         afma_pkg::OP_ORR: begin
            arith = 1'b0;
            logic_r = OP_A | OP_B;
         end
         afma_pkg::OP_MOV: begin
            arith = 1'b0;
            logic_r = OP_B;
         end
         afma_pkg::OP_BIC: begin
            arith = 1'b0;
            logic_r = OP_A & ~OP_B;
         end
         afma_pkg::OP_MVN: begin
            arith = 1'b0;
            logic_r = ~OP_B;
         end
         afma_pkg::OP_SUB, afma_pkg::OP_CMP: begin
            alu_y = ~OP_B;
            alu_ci = 1'b1;
         end
         afma_pkg::OP_RSB: begin
            alu_x = OP_B;
            alu_y = ~OP_A;
            alu_ci = 1'b1;
         end
         afma_pkg::OP_ADC: alu_ci = flg_q.c;
         afma_pkg::OP_SBC: begin
            alu_y = ~OP_B;
            alu_ci = flg_q.c;
         end
         afma_pkg::OP_RSC: begin
            alu_x = OP_B;
            alu_y = ~OP_A;
            alu_ci = flg_q.c;
         end
         default: alu_ci = 1'b0;
      endcase
      sum = {1'b0, alu_x} + {1'b0, alu_y} + {32'h0, alu_ci};
      alu_r = arith ? sum[31:0] : logic_r;
      alu_c = arith ? sum[32] : SHIFT_CARRY; // [RULE3] [RULE4]
      alu_v = arith ? ((alu_x[31] == alu_y[31]) && // [RULE5]
         (sum[31] != alu_x[31])) : flg_q.v;
   end

   // short forms accumulate one register, long forms the register pair
   always_comb begin
      mul_acc = 64'h0;
      if (INSTR[afma_pkg::B_A]) begin
         mul_acc = (cls == afma_pkg::CL_MULL) ? {OP_D, OP_A} : // [RULE10]
            {32'h0, OP_A}; // [RULE7]
      end
   end

   // low word is sign-independent, so short forms run unsigned
   afma_mul u_mul (
      .a(OP_B),
      .b(OP_C),
      .acc(mul_acc),
      .sgn((cls == afma_pkg::CL_MULL) & INSTR[afma_pkg::B_SGN]), // [RULE9]
      .res(mul_r)
   );

   // address generation for word/byte and halfword/signed forms
   always_comb begin
      size_d = afma_pkg::SZ_WORD;
      lk_d = afma_pkg::LK_WORD;
      if (cls == afma_pkg::CL_LSH) begin
         // no scaled form here, immediate split in two nibbles
         offs = INSTR[afma_pkg::B_HIMM] ? // [RULE22]
            {24'h0, INSTR[afma_pkg::HOFF_HI:afma_pkg::HOFF_LO],
             INSTR[afma_pkg::LOFF_HI:0]} : OP_B;
         size_d = INSTR[afma_pkg::B_HH] ? afma_pkg::SZ_HALF :
            afma_pkg::SZ_BYTE;
         if (!INSTR[afma_pkg::B_HS]) begin
            lk_d = afma_pkg::LK_UHALF;
         end else begin
            lk_d = INSTR[afma_pkg::B_HH] ? afma_pkg::LK_SHALF : // [RULE15]
               afma_pkg::LK_SBYTE;
         end
      end else if (INSTR[afma_pkg::B_I]) begin
         offs = shift_imm(OP_B, INSTR[afma_pkg::SHA_HI:afma_pkg::SHA_LO],
            afma_pkg::afma_sh_e'(INSTR[afma_pkg::SHT_HI:afma_pkg::SHT_LO]),
            flg_q.c); // [RULE17] [RULE18]
      end else begin
         offs = {20'h0, INSTR[afma_pkg::IMM12_HI:0]}; // [RULE16]
      end
      if (cls == afma_pkg::CL_LSW && INSTR[afma_pkg::B_B]) begin
         size_d = afma_pkg::SZ_BYTE;
         lk_d = afma_pkg::LK_UBYTE;
      end
      calc = INSTR[afma_pkg::B_U] ? OP_A + offs : OP_A - offs;
   end

   // current status: flag updates and masked moves
   always_ff @(posedge CLK) begin
      if (SRST) begin
         cps_q <= afma_pkg::SR_RESET;
      end else if (ISSUE) begin
         case (cls)
            afma_pkg::CL_DP: begin
               if (s_bit || is_cmp) begin // [RULE24] [RULE25]
                  cps_q[afma_pkg::SR_N] <= alu_r[31]; // [RULE1]
                  cps_q[afma_pkg::SR_Z] <= (alu_r == 32'h0); // [RULE2]
                  cps_q[afma_pkg::SR_C] <= alu_c; // [RULE3] [RULE4]
                  cps_q[afma_pkg::SR_V] <= alu_v; // [RULE5]
               end
            end
            afma_pkg::CL_MUL: begin
               if (s_bit) begin // [RULE8]
                  cps_q[afma_pkg::SR_N] <= mul_r[31];
                  cps_q[afma_pkg::SR_Z] <= (mul_r[31:0] == 32'h0);
               end
            end
            afma_pkg::CL_MULL: begin
               if (s_bit) begin // [RULE10]
                  cps_q[afma_pkg::SR_N] <= mul_r[63];
                  cps_q[afma_pkg::SR_Z] <= (mul_r == 64'h0);
               end
            end
            afma_pkg::CL_MSR: begin
               if (!INSTR[afma_pkg::B_R]) begin // [RULE11] [RULE12]
                  cps_q <= sr_merge(cps_q, msr_val,
                     INSTR[afma_pkg::MSK_LO +: 4]); // [RULE13] [RULE14]
               end
            end
            default: cps_q <= cps_q;
         endcase
      end
   end

   // saved status: only moves reach it
   always_ff @(posedge CLK) begin
      if (SRST) begin
         sps_q <= afma_pkg::SR_RESET;
      end else if (ISSUE && cls == afma_pkg::CL_MSR &&
                   INSTR[afma_pkg::B_R]) begin
         sps_q <= sr_merge(sps_q, msr_val,
            INSTR[afma_pkg::MSK_LO +: 4]); // [RULE11] [RULE12]
      end
   end

   assign STATUS = cps_q;
   assign SAVED_STATUS = sps_q;

   // register results, one cycle after issue
   always_ff @(posedge CLK) begin
      if (SRST) begin
         DONE <= 1'b0;
         RESULT <= 32'h0;
         RESULT_HI <= 32'h0;
         RD_WE <= 1'b0;
         RD_HI_WE <= 1'b0;
      end else begin
         DONE <= ISSUE;
         RD_WE <= 1'b0;
         RD_HI_WE <= 1'b0;
         if (ISSUE) begin
            case (cls)
               afma_pkg::CL_DP: begin
                  RESULT <= alu_r;
                  RD_WE <= !is_cmp; // [RULE25]
               end
               afma_pkg::CL_MUL: begin
                  RESULT <= mul_r[31:0]; // [RULE6] [RULE7]
                  RD_WE <= 1'b1;
               end
               afma_pkg::CL_MULL: begin
                  RESULT <= mul_r[31:0]; // [RULE9]
                  RESULT_HI <= mul_r[63:32];
                  RD_WE <= 1'b1;
                  RD_HI_WE <= 1'b1;
               end
               afma_pkg::CL_MRS: begin
                  RESULT <= INSTR[afma_pkg::B_R] ? sps_q : cps_q; // [RULE11]
                  RD_WE <= 1'b1;
               end
               default: RESULT <= RESULT;
            endcase
         end
      end
   end

   // memory request and base writeback
   always_ff @(posedge CLK) begin
      if (SRST) begin
         MEM_REQ <= 1'b0;
         MEM_OUT <= '0;
         BASE_WE <= 1'b0;
         BASE_VALUE <= 32'h0;
      end else begin
         MEM_REQ <= 1'b0;
         BASE_WE <= 1'b0;
         if (ISSUE && (cls == afma_pkg::CL_LSW ||
                       cls == afma_pkg::CL_LSH)) begin
            MEM_REQ <= 1'b1;
            MEM_OUT.write <= !INSTR[afma_pkg::B_L];
            MEM_OUT.size <= size_d; // [RULE15]
            MEM_OUT.wdata <= OP_C;
            // post-indexed uses the bare base
            MEM_OUT.addr <= INSTR[afma_pkg::B_P] ? calc : OP_A; // [RULE19] [RULE21]
            // post always writes back, pre only with W
            BASE_WE <= !INSTR[afma_pkg::B_P] ||
               INSTR[afma_pkg::B_W]; // [RULE20] [RULE21]
            BASE_VALUE <= calc;
         end
      end
   end

   // load kind remembered for the single outstanding load
   always_ff @(posedge CLK) begin
      if (SRST) begin
         lk_q <= afma_pkg::LK_WORD;
      end else if (ISSUE && (cls == afma_pkg::CL_LSW ||
                   cls == afma_pkg::CL_LSH) && INSTR[afma_pkg::B_L]) begin
         lk_q <= lk_d;
      end
   end

   // load return extension
   always_ff @(posedge CLK) begin
      if (SRST) begin
         LOAD_VALID <= 1'b0;
         LOAD_DATA <= 32'h0;
      end else begin
         LOAD_VALID <= MEM_RVALID;
         if (MEM_RVALID) begin
            LOAD_DATA <= extend(MEM_RDATA, lk_q); // [RULE23] [RULE26]
         end
      end
   end

   chk_neg_flag: assert property (@(posedge CLK) disable iff (SRST) // [RULE1]
      (ISSUE && cls == afma_pkg::CL_DP && (s_bit || is_cmp))
      |=> STATUS[31] == RESULT[31])
      else $error("negative flag differs from result sign");
   chk_zero_flag: assert property (@(posedge CLK) disable iff (SRST) // [RULE2]
      (ISSUE && cls == afma_pkg::CL_DP && (s_bit || is_cmp))
      |=> STATUS[30] == (RESULT == 32'h0))
      else $error("zero flag differs from result");
   chk_shift_carry: assert property (@(posedge CLK) disable iff (SRST) // [RULE4]
      (ISSUE && cls == afma_pkg::CL_DP && s_bit && !arith)
      |=> STATUS[29] == $past(SHIFT_CARRY))
      else $error("logical carry not from shifter");
   chk_v_hold: assert property (@(posedge CLK) disable iff (SRST) // [RULE5]
      (ISSUE && cls == afma_pkg::CL_DP && !arith) |=> $stable(STATUS[28]))
      else $error("overflow changed by logical op");
   chk_no_s_hold: assert property (@(posedge CLK) disable iff (SRST) // [RULE24]
      (ISSUE && cls == afma_pkg::CL_DP && !s_bit && !is_cmp)
      |=> $stable(STATUS[31:28]))
      else $error("flags changed without update bit");
   chk_cmp_nowrite: assert property (@(posedge CLK) disable iff (SRST) // [RULE25]
      (ISSUE && cls == afma_pkg::CL_DP && is_cmp) |=> DONE && !RD_WE)
      else $error("compare wrote a register");
   chk_mul_low: assert property (@(posedge CLK) disable iff (SRST) // [RULE6]
      (ISSUE && cls == afma_pkg::CL_MUL && !INSTR[afma_pkg::B_A])
      |=> RD_WE && RESULT == 32'($past(OP_B) * $past(OP_C)))
      else $error("plain multiply low word wrong");
   chk_post_addr: assert property (@(posedge CLK) disable iff (SRST) // [RULE21]
      (ISSUE && (cls == afma_pkg::CL_LSW || cls == afma_pkg::CL_LSH) &&
       !INSTR[afma_pkg::B_P])
      |=> MEM_REQ && BASE_WE && MEM_OUT.addr == $past(OP_A))
      else $error("post-indexed address not the base");
   chk_pre_wb: assert property (@(posedge CLK) disable iff (SRST) // [RULE20]
      (ISSUE && cls == afma_pkg::CL_LSW && INSTR[afma_pkg::B_P] &&
       INSTR[afma_pkg::B_W]) |=> BASE_WE && BASE_VALUE == MEM_OUT.addr)
      else $error("pre-indexed writeback differs from address");
   chk_uhalf_zero: assert property (@(posedge CLK) disable iff (SRST) // [RULE23]
      (MEM_RVALID && lk_q == afma_pkg::LK_UHALF)
      |=> LOAD_VALID && LOAD_DATA[31:16] == 16'h0)
      else $error("unsigned halfword top not zero");
   chk_sbyte_ext: assert property (@(posedge CLK) disable iff (SRST) // [RULE26]
      (MEM_RVALID && lk_q == afma_pkg::LK_SBYTE)
      |=> LOAD_DATA[31:8] == {24{LOAD_DATA[7]}})
      else $error("signed byte not extended");
   chk_msr_field: assert property (@(posedge CLK) disable iff (SRST) // [RULE12]
      (ISSUE && cls == afma_pkg::CL_MSR && !INSTR[afma_pkg::B_R] &&
       !INSTR[afma_pkg::MSK_LO + 3]) |=> $stable(STATUS[31:24]))
      else $error("flags field written while masked");

endmodule // afma_core

// ===== dv/afma_mem_model.sv
// memory partner answering single-register loads and stores
`timescale 1ns/1ps
module afma_mem_model (
   // clock, reset and pace
   input wire logic clk,
   input wire logic srst,
   input wire logic slow,
   // request from the datapath
   input wire logic req,
   input wire afma_pkg::afma_memreq_s mreq,
   // load return
   output logic rvalid,
   output logic [31:0] rdata
);
   logic [31:0] mem [0:15];
   logic [31:0] ad_q;
   logic [1:0] wait_q;
   logic busy_q;
   logic [3:0] wi;
   logic [4:0] wl;

   // word index and lane offset of the request
   assign wi = mreq.addr[5:2];
   assign wl = {mreq.addr[1:0], 3'b000};

   // stores merge only the addressed lanes
   always_ff @(posedge clk) begin
      if (req && mreq.write) begin
         case (mreq.size)
            afma_pkg::SZ_BYTE: mem[wi][wl +: 8] <= mreq.wdata[7:0];
            afma_pkg::SZ_HALF: mem[wi][wl +: 16] <= mreq.wdata[15:0];
            default: mem[wi] <= mreq.wdata;
         endcase
      end
   end

   // loads answer promptly or late; an idle bus toggles, never holds
   always_ff @(posedge clk) begin
      rvalid <= 1'b0;
      rdata <= ~rdata;
      if (srst) begin
         busy_q <= 1'b0;
         wait_q <= 2'h0;
         ad_q <= 32'h0;
      end else if (req && !mreq.write) begin
         busy_q <= 1'b1;
         ad_q <= mreq.addr;
         wait_q <= slow ? 2'h3 : 2'h0;
      end else if (busy_q && wait_q != 2'h0) begin
         wait_q <= wait_q - 2'h1;
      end else if (busy_q) begin
         busy_q <= 1'b0;
         rvalid <= 1'b1;
         // upper lanes keep neighbour bytes: the core must trim them
         rdata <= mem[ad_q[5:2]] >> {ad_q[1:0], 3'b000};
      end
   end
endmodule // afma_mem_model

// ===== dv/alu_flags_mul_agu_tb_top.sv
// self-checking bench for the execution datapath and its memory partner
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin \
n_mismatch++; $display("Error %s expected %h seen %h", nm, ex, gt); end end
module alu_flags_mul_agu_tb_top;
   typedef struct packed {
      logic [31:0] i, a, b, c, d;
      logic s;
      logic [31:0] r, h;
      logic [3:0] f;
      logic [1:0] we;
   } afma_row_s;
   localparam logic [31:0] z32 = 32'h0;
   localparam logic [31:0] ones = 32'hffffffff;
   localparam logic [31:0] msb = 32'h80000000;
   afma_row_s rows [13];
   logic clk, srst, issue, shc, slow;
   logic [31:0] instr, op_a, op_b, op_c, op_d;
   logic done, rd_we, rd_hi_we, mem_req, base_we, mem_rvalid, load_valid;
   logic [31:0] result, result_hi, status, saved, base_value, mem_rdata;
   logic [31:0] load_data;
   afma_pkg::afma_memreq_s mem_out;
   int n_mismatch = 0;
   int checks_done = 0;
   int cyc = 0;

   afma_core afma_core_inst (.CLK(clk), .SRST(srst), .ISSUE(issue),
      .INSTR(instr), .OP_A(op_a), .OP_B(op_b), .OP_C(op_c), .OP_D(op_d),
      .SHIFT_CARRY(shc), .DONE(done), .RESULT(result),
      .RESULT_HI(result_hi), .RD_WE(rd_we), .RD_HI_WE(rd_hi_we),
      .STATUS(status), .SAVED_STATUS(saved), .MEM_REQ(mem_req),
      .MEM_OUT(mem_out), .BASE_WE(base_we), .BASE_VALUE(base_value),
      .MEM_RVALID(mem_rvalid), .MEM_RDATA(mem_rdata),
      .LOAD_VALID(load_valid), .LOAD_DATA(load_data));
   afma_mem_model afma_mem_model_inst (.clk(clk), .srst(srst),
      .slow(slow), .req(mem_req), .mreq(mem_out), .rvalid(mem_rvalid),
      .rdata(mem_rdata));

   // 125 MHz core clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // data-processing word: k holds opcode and flag-update bit
   function automatic logic [31:0] dp(input logic [4:0] k);
      return {4'he, 3'b000, k, 20'h0};
   endfunction
   // multiply word: k holds long, signed, accumulate, flag-update
   function automatic logic [31:0] ml(input logic [3:0] k);
      return {4'he, 4'h0, k, 12'h0, 4'h9, 4'h0};
   endfunction

   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // one issue, spaced from the last so issue never flips twice a step
   task automatic op(input logic [31:0] i, a, b, c, d, input logic s);
      @(posedge clk);
      #1;
      {instr, op_a, op_b, op_c, op_d, shc} = {i, a, b, c, d, s};
      issue = 1'b1;
      @(posedge clk);
      #1;
      issue = 1'b0;
      `CHK("done", 1'b1, done)
   endtask

   task automatic mem(input logic [31:0] i, a, b, c, input logic [2:0] ctl,
      input logic [31:0] ad, input logic bwe, input logic [31:0] bv, ld);
      int k;
      op(i, a, b, c, z32, 1'b0);
      `CHK("mem_req", 1'b1, mem_req)
      `CHK("mem_ctl", ctl, {mem_out.write, mem_out.size})
      `CHK("mem_addr", ad, mem_out.addr)
      `CHK("base_we", bwe, base_we)
      if (bwe) `CHK("base_value", bv, base_value)
      if (ctl[2]) `CHK("wdata", c, mem_out.wdata)
      if (!ctl[2]) begin
         for (k = 0; k < 8 && load_valid !== 1'b1; k++) begin
            @(posedge clk);
            #1;
         end
         `CHK("load_valid", 1'b1, load_valid)
         `CHK("load_data", ld, load_data)
      end
   endtask

   // hang guard, far above the fewer than one hundred cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         n_mismatch++;
         results();
      end
   end

   initial begin
      {issue, shc, slow, srst} = 4'h1;
      {instr, op_a, op_b, op_c, op_d} = '0;
      rows = '{
         '{dp(5'h09), 32'h7fffffff, 32'h1, z32, z32, 1'b0, msb, z32, 4'h9, 2'h1},
         '{dp(5'h01), msb, ones, z32, z32, 1'b1, msb, z32, 4'hb, 2'h1},
         '{dp(5'h15), 32'h1, 32'h2, z32, z32, 1'b0, ones, z32, 4'h8, 2'h0},
         '{dp(5'h08), 32'h3, 32'h4, z32, z32, 1'b1, 32'h7, z32, 4'h8, 2'h1},
         '{dp(5'h13), 32'h5, 32'h5, z32, z32, 1'b1, z32, z32, 4'h6, 2'h0},
         '{dp(5'h17), msb, msb, z32, z32, 1'b0, z32, z32, 4'h7, 2'h0},
         '{dp(5'h11), msb, ones, z32, z32, 1'b0, msb, z32, 4'h9, 2'h0},
         '{ml(4'h1), z32, ones, 32'h2, z32, 1'b0, ~32'h1, z32, 4'h9, 2'h1},
         '{ml(4'h3), 32'h5, 32'h10000, 32'h10000, z32, 1'b0, 32'h5, z32,
            4'h1, 2'h1},
         '{ml(4'h8), z32, ones, 32'h2, z32, 1'b0, ~32'h1, 32'h1, 4'h1, 2'h3},
         '{ml(4'hd), z32, ones, 32'h2, z32, 1'b0, ~32'h1, ones, 4'h9, 2'h3},
         '{ml(4'hb), ones, 32'h2, 32'h3, 32'h1, 1'b0, 32'h5, 32'h2, 4'h1, 2'h3},
         '{dp(5'h05), 32'h3, 32'h5, z32, z32, 1'b0, ~32'h1, z32, 4'h8, 2'h1}
      };
      repeat (8) @(posedge clk);
      #1;
      srst = 1'b0;
      foreach (rows[n]) begin
         op(rows[n].i, rows[n].a, rows[n].b, rows[n].c, rows[n].d, rows[n].s);
         `CHK("result", rows[n].r, result)
         `CHK("rd_we", rows[n].we[0], rd_we)
         `CHK("rd_hi_we", rows[n].we[1], rd_hi_we)
         if (rows[n].we[1]) `CHK("result_hi", rows[n].h, result_hi)
         `CHK("flags", rows[n].f, status[31:28])
      end
      $display("test table done");
      // field-masked writes: unused fields stay zero
      op(32'he129f000, z32, ones, z32, z32, 1'b0);
      `CHK("status", 32'hf00000ff, status)
      op(32'he126f000, z32, ones, z32, z32, 1'b0);
      `CHK("status", 32'hf00000ff, status)
      op(32'he128f000, z32, z32, z32, z32, 1'b0);
      `CHK("status", 32'h000000ff, status)
      op(32'he161f000, z32, 32'h12345678, z32, z32, 1'b0);
      `CHK("saved", 32'h00000078, saved)
      op(32'he14f0000, z32, z32, z32, z32, 1'b0);
      `CHK("read saved", 32'h00000078, result)
      $display("test status moves done");
      mem(32'he5a00004, 32'h100, z32, 32'hcafef00d, 3'h6, 32'h104, 1'b1,
         32'h104, z32);
      slow = 1'b1;
      mem(32'he5d00000, 32'h107, z32, z32, 3'h0, 32'h107, 1'b0, z32,
         32'h000000ca);
      slow = 1'b0;
      mem(32'he15001d1, 32'h117, z32, z32, 3'h0, 32'h106, 1'b0, z32,
         32'hfffffffe);
      mem(32'he09000b0, 32'h106, 32'h10, z32, 3'h1, 32'h106, 1'b1, 32'h116,
         32'h0000cafe);
      mem(32'he09000f0, 32'h106, 32'h10, z32, 3'h1, 32'h106, 1'b1, 32'h116,
         32'hffffcafe);
      mem(32'he7100120, 32'h108, 32'h10, z32, 3'h2, 32'h104, 1'b0, z32,
         32'hcafef00d);
      $display("test memory done");
      // mid-run reset restores both status registers
      srst = 1'b1;
      @(posedge clk);
      #1;
      `CHK("status", 32'h000000c0, status)
      `CHK("saved", 32'h000000c0, saved)
      srst = 1'b0;
      $display("test reset done");
      results();
   end
endmodule // alu_flags_mul_agu_tb_top
